// ---- src/adcs_top.sv ----
// ADC input select, reference select and result format control with AXI4-Lite
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "adcs_defs.svh"

// Summary of operation
// - The stored result changes only when a conversion finishes and flag sets.
// - Single-ended result unsigned, 0x000 ground to 0x3FF, clamped at top.
// - Differential result two's complement 0x200..0x1FF, saturating at ends.
// - Bit 9 of the result, in result_high, is the sign.
// - input_select_reg: ref_sel 7:6, left_justify 5, chan_gain_sel_lo 4:0.
// - ref_sel: 00 external pin, 01 analog supply, 10 1.1V, 11 2.56V.
// - Selector and reference writes apply only between conversions.
// - left_justify reformats the result bytes at once, even mid-conversion.
// - conv_ctrl_b_reg: comparator mux 6, sel_hi 3, trigger 2:0; 7,5,4 RO.
// - chan_gain_sel_hi is bit 5 of the six-bit selector.
// - Codes 0..7 pick single-ended inputs 0..7.
// - Codes 8..15 amplified pairs: bit0 positive, bit1 gain, bit2 negative.
// - Codes 16..18 pick inputs 0..2 against input 1 at unity gain.
// - trigger_src_sel picks the rising edge that starts auto conversions.
module adcs_top
  import adcs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter core side
  input  wire logic [7:0]  trig_in,
  input  wire logic        conv_done_in,
  input  wire logic [10:0] conv_raw,
  output logic             conv_start,
  output logic             sel_diff,
  output logic [3:0]       sel_pos_ch,
  output logic [3:0]       sel_neg_ch,
  output logic [1:0]       sel_gain,
  output logic [1:0]       sel_special,
  output logic [1:0]       ref_active,
  output logic             int_ref_en,
  output logic             cmp_mux_en,
  // Interrupt
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Raw converter value to 10-bit code; the raw value has one guard bit
  function automatic logic [9:0] sat_code(input logic [10:0] raw,
                                          input logic diff);
    logic [9:0] c;
    c = raw[9:0];
    if (diff) begin
      if ($signed(raw) > `ADCS_DIFF_HI_S) c = `ADCS_DIFF_MAX;
      if ($signed(raw) < `ADCS_DIFF_LO_S) c = `ADCS_DIFF_MIN;
    end else if (raw[10]) begin
      c = `ADCS_SE_MAX;
    end
    return c;
  endfunction : sat_code

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0]  insel_r, insel_nxt;
  logic [7:0]  ctrlb_r, ctrlb_nxt;
  logic        auto_r, auto_nxt;
  logic        done_flag_r, done_flag_nxt;
  logic        mask_r, mask_nxt;
  logic [9:0]  result_r, result_nxt;
  logic [7:0]  trig_prev_r;
  adcs_conv_e  conv_r, conv_nxt;
  adcs_sel_s   act_r, act_nxt;
  logic [1:0]  ref_r, ref_nxt;
  logic        start_r, start_nxt;
  logic        irq_r, irq_nxt;
  // Bus state
  logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic        have_aw_r, have_aw_nxt, have_w_r, have_w_nxt;
  logic [7:0]  waddr_r, waddr_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arrdy_r, arrdy_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  logic        do_wr, rd_take, sw_start, trig_edge;

  adcs_fmt_if fmt_bus ();
  assign fmt_bus.result       = result_r;
  assign fmt_bus.left_justify = insel_r[`ADCS_INSEL_LADJ];

  adcs_fmt u_fmt (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .fi      (fmt_bus)
  );

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  // Address and data are taken in either order; one write outstanding
  always_comb begin
    have_aw_nxt = have_aw_r;
    have_w_nxt  = have_w_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    do_wr       = 1'b0;
    if (s_axi_awvalid && awrdy_r) begin
      have_aw_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_r) begin
      have_w_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata[7:0];
      wstrb_nxt  = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (have_aw_r && have_w_r && !bvalid_r) begin
      do_wr       = 1'b1;
      have_aw_nxt = 1'b0;
      have_w_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      case (waddr_r)
        `ADCS_OFF_INSEL, `ADCS_OFF_CTRLB, `ADCS_OFF_CONV,
        `ADCS_OFF_RES_LOW, `ADCS_OFF_RES_HIGH,
        `ADCS_OFF_IRQ_STAT, `ADCS_OFF_IRQ_MASK: bresp_nxt = `ADCS_RESP_OKAY;
        default: bresp_nxt = `ADCS_RESP_SLVERR;
      endcase
    end
    awrdy_nxt = !have_aw_nxt && !bvalid_nxt;
    wrdy_nxt  = !have_w_nxt && !bvalid_nxt;
  end

  always_comb begin
    rd_take    = s_axi_arvalid && arrdy_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `ADCS_RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (s_axi_araddr)
        `ADCS_OFF_INSEL:    rdata_nxt[7:0] = insel_r;
        `ADCS_OFF_CTRLB:    rdata_nxt[7:0] = ctrlb_r;
        `ADCS_OFF_CONV:
          rdata_nxt[1:0] = {conv_r == CONV_BUSY, auto_r};
        `ADCS_OFF_RES_LOW:  rdata_nxt[7:0] = fmt_bus.res_low;
        `ADCS_OFF_RES_HIGH: rdata_nxt[7:0] = fmt_bus.res_high;
        `ADCS_OFF_IRQ_STAT: rdata_nxt[0]   = done_flag_r;
        `ADCS_OFF_IRQ_MASK: rdata_nxt[0]   = mask_r;
        default:            rresp_nxt      = `ADCS_RESP_SLVERR;
      endcase
    end
    arrdy_nxt = !rvalid_nxt;
  end

  // --------------------------------------------------------------------------
  // Registers and conversion control
  // --------------------------------------------------------------------------
  always_comb begin
    insel_nxt = insel_r;
    ctrlb_nxt = ctrlb_r;
    auto_nxt  = auto_r;
    mask_nxt  = mask_r;
    sw_start  = 1'b0;
    if (do_wr && wstrb_r) begin
      case (waddr_r)
        `ADCS_OFF_INSEL: insel_nxt = wdata_r;
        `ADCS_OFF_CTRLB:
          ctrlb_nxt = wdata_r & `ADCS_CTRLB_WR_MASK;
        `ADCS_OFF_CONV: begin
          auto_nxt = wdata_r[`ADCS_CONV_AUTO];
          sw_start = wdata_r[`ADCS_CONV_START];
        end
        `ADCS_OFF_IRQ_MASK: mask_nxt = wdata_r[`ADCS_IRQ_DONE];
        default: ;
      endcase
    end
  end

  always_comb begin
    trig_edge     = trig_in[ctrlb_r[2:0]] &&
                    !trig_prev_r[ctrlb_r[2:0]];
    conv_nxt      = conv_r;
    result_nxt    = result_r;
    start_nxt     = 1'b0;
    act_nxt       = act_r;
    ref_nxt       = ref_r;
    done_flag_nxt = done_flag_r;
    // Status read clears first so a completion in the same cycle still sets
    if (rd_take && s_axi_araddr == `ADCS_OFF_IRQ_STAT) done_flag_nxt = 1'b0;
    case (conv_r)
      CONV_IDLE: begin
        // Staged selection reaches the analog side only between conversions
        act_nxt = adcs_decode({ctrlb_r[`ADCS_CTRLB_MUXHI],
                               insel_r[`ADCS_INSEL_MUX_HI:0]});
        ref_nxt = insel_r[`ADCS_INSEL_REF_HI:`ADCS_INSEL_REF_LO];
        if (sw_start || (auto_r && trig_edge)) begin
          start_nxt = 1'b1;
          conv_nxt  = CONV_BUSY;
        end
      end
      CONV_BUSY: begin
        if (conv_done_in) begin
          result_nxt    = sat_code(conv_raw, act_r.diff);
          done_flag_nxt = 1'b1;
          conv_nxt      = CONV_IDLE;
        end
      end
      default: conv_nxt = CONV_IDLE;
    endcase
    irq_nxt = done_flag_nxt && mask_nxt;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      insel_r     <= `ADCS_RST_INSEL;
      ctrlb_r     <= `ADCS_RST_CTRLB;
      auto_r      <= 1'b0;
      mask_r      <= 1'b0;
      done_flag_r <= 1'b0;
      result_r    <= 10'h000;
      trig_prev_r <= 8'h00;
      conv_r      <= CONV_IDLE;
      act_r       <= '{diff: 1'b0, pos: 4'h0, neg: 4'h0,
                       gain: GAIN_1X, spc: SPC_NONE};
      ref_r       <= 2'b00;
      start_r     <= 1'b0;
      irq_r       <= 1'b0;
      awrdy_r     <= 1'b0;
      wrdy_r      <= 1'b0;
      have_aw_r   <= 1'b0;
      have_w_r    <= 1'b0;
      waddr_r     <= 8'h00;
      wdata_r     <= 8'h00;
      wstrb_r     <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= 2'b00;
      arrdy_r     <= 1'b0;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      rresp_r     <= 2'b00;
    end else if (ce) begin
      insel_r     <= insel_nxt;
      ctrlb_r     <= ctrlb_nxt;
      auto_r      <= auto_nxt;
      mask_r      <= mask_nxt;
      done_flag_r <= done_flag_nxt;
      result_r    <= result_nxt;
      trig_prev_r <= trig_in;
      conv_r      <= conv_nxt;
      act_r       <= act_nxt;
      ref_r       <= ref_nxt;
      start_r     <= start_nxt;
      irq_r       <= irq_nxt;
      awrdy_r     <= awrdy_nxt;
      wrdy_r      <= wrdy_nxt;
      have_aw_r   <= have_aw_nxt;
      have_w_r    <= have_w_nxt;
      waddr_r     <= waddr_nxt;
      wdata_r     <= wdata_nxt;
      wstrb_r     <= wstrb_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      arrdy_r     <= arrdy_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready  = wrdy_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign conv_start    = start_r;
  assign sel_diff      = act_r.diff;
  assign sel_pos_ch    = act_r.pos;
  assign sel_neg_ch    = act_r.neg;
  assign sel_gain      = act_r.gain;
  assign sel_special   = act_r.spc;
  assign ref_active    = ref_r;
  // Internal reference is powered only for codes 10 and 11
  assign int_ref_en    = ref_r[1];
  assign cmp_mux_en    = ctrlb_r[`ADCS_CTRLB_CMPMUX];
  assign irq           = irq_r;

endmodule : adcs_top

// ---- pkg/adcs_defs.svh ----
// Register offsets, field positions, reset values and codes of the ADC select block
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADCS_OFF_INSEL    8'h00
`define ADCS_OFF_CTRLB    8'h04
`define ADCS_OFF_CONV     8'h08
`define ADCS_OFF_RES_LOW  8'h0C
`define ADCS_OFF_RES_HIGH 8'h10
`define ADCS_OFF_IRQ_STAT 8'h14
`define ADCS_OFF_IRQ_MASK 8'h18

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define ADCS_INSEL_REF_HI   7
`define ADCS_INSEL_REF_LO   6
`define ADCS_INSEL_LADJ     5
`define ADCS_INSEL_MUX_HI   4
`define ADCS_CTRLB_CMPMUX   6
`define ADCS_CTRLB_MUXHI    3
`define ADCS_CTRLB_WR_MASK  8'h4F
`define ADCS_CONV_AUTO      0
`define ADCS_CONV_START     1
`define ADCS_IRQ_DONE       0
`define ADCS_RST_INSEL      8'h00
`define ADCS_RST_CTRLB      8'h00

// ----------------------------------------------------------------------------
// Result codes and bus answers
// ----------------------------------------------------------------------------
`define ADCS_SE_MAX    10'h3FF
`define ADCS_DIFF_MAX  10'h1FF
`define ADCS_DIFF_MIN  10'h200
`define ADCS_DIFF_HI_S 11'sh1FF
`define ADCS_DIFF_LO_S (-11'sh200)
`define ADCS_RESP_OKAY   2'b00
`define ADCS_RESP_SLVERR 2'b10

`endif

// ---- pkg/adcs_pkg.sv ----
// Types and the input selector decode of the ADC select block
package adcs_pkg;

  typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} adcs_gain_e;
  typedef enum logic [1:0] {SPC_NONE, SPC_BANDGAP, SPC_GND, SPC_RSVD}
    adcs_spc_e;
  typedef enum logic {CONV_IDLE, CONV_BUSY} adcs_conv_e;

  typedef struct packed {
    logic       diff;
    logic [3:0] pos;
    logic [3:0] neg;
    adcs_gain_e gain;
    adcs_spc_e  spc;
  } adcs_sel_s;

  // Six-bit selector to input routing; bit 5 moves to the upper bank
  function automatic adcs_sel_s adcs_decode(input logic [5:0] sel);
    adcs_sel_s d;
    logic [3:0] bank;
    d    = '{diff: 1'b0, pos: 4'h0, neg: 4'h0, gain: GAIN_1X, spc: SPC_NONE};
    bank = {sel[5], 3'b000};
    case (sel[4:3])
      2'b00: begin
        d.pos = bank | {1'b0, sel[2:0]};
      end
      2'b01: begin
        d.diff = 1'b1;
        d.neg  = bank | {2'b00, sel[2], 1'b0};
        d.pos  = bank | {2'b00, sel[2], sel[0]};
        d.gain = sel[1] ? GAIN_200X : GAIN_10X;
      end
      2'b10: begin
        d.diff = 1'b1;
        d.pos  = bank | {1'b0, sel[2:0]};
        d.neg  = bank | 4'h1;
      end
      default: begin
        if (sel[2:1] == 2'b11) begin
          d.spc = sel[5] ? SPC_RSVD : (sel[0] ? SPC_GND : SPC_BANDGAP);
        end else begin
          d.diff = 1'b1;
          d.pos  = bank | {1'b0, sel[2:0]};
          d.neg  = bank | 4'h2;
        end
      end
    endcase
    return d;
  endfunction : adcs_decode

endpackage : adcs_pkg

// ---- pkg/adcs_fmt_if.sv ----
// Carrier between the control core and the result formatter
`timescale 1ns/1ps
interface adcs_fmt_if;
  logic [9:0] result;
  logic       left_justify;
  logic [7:0] res_low;
  logic [7:0] res_high;
  modport core (output result, output left_justify,
                input res_low, input res_high);
  modport fmt  (input result, input left_justify,
                output res_low, output res_high);
endinterface : adcs_fmt_if

// ---- src/adcs_fmt.sv ----
// Result formatter: justification of the stored result into two bytes
`timescale 1ns/1ps
module adcs_fmt
  import adcs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic ce,
  // Core side
  adcs_fmt_if.fmt   fi
);

  logic [7:0] low_r;
  logic [7:0] high_r;
  logic [7:0] low_nxt;
  logic [7:0] high_nxt;

  // Follows the justify bit every cycle, so a change shows even mid-conversion
  always_comb begin
    if (fi.left_justify) begin
      high_nxt = fi.result[9:2];
      low_nxt  = {fi.result[1:0], 6'b00_0000};
    end else begin
      high_nxt = {6'b00_0000, fi.result[9:8]};
      low_nxt  = fi.result[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_r  <= 8'h00;
      high_r <= 8'h00;
    end else if (ce) begin
      low_r  <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign fi.res_low  = low_r;
  assign fi.res_high = high_r;

endmodule : adcs_fmt

// ---- testbench/adcs_analog_model.sv ----
// Behavioural analog core: answers each start after a set latency
`timescale 1ns/1ps
module adcs_analog_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Bench control
  input  wire logic [10:0] raw_set,
  input  wire logic [7:0]  lat,
  // Converter side
  input  wire logic        conv_start,
  output logic             conv_done_in,
  output logic [10:0]      conv_raw
);
  logic [7:0]  cnt_r;
  logic        done_r;
  logic [10:0] raw_r;
  assign conv_done_in = done_r;
  assign conv_raw     = raw_r;
  // Raw lines toggle outside the done cycle, so a stale value never matches
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= 8'h00;
      done_r <= 1'b0;
      raw_r  <= 11'h000;
    end else begin
      done_r <= 1'b0;
      raw_r  <= ~raw_r;
      if (conv_start) begin
        cnt_r <= lat;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          done_r <= 1'b1;
          raw_r  <= raw_set;
        end
      end
    end
  end
endmodule : adcs_analog_model

// ---- testbench/adcs_top_monitor.sv ----
// Concurrent checks on the ports of the converter select block
`timescale 1ns/1ps
module adcs_top_monitor (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Register bus
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Converter side
  input wire logic       conv_start,
  input wire logic       conv_done_in,
  input wire logic       sel_diff,
  input wire logic [3:0] sel_pos_ch,
  input wire logic [3:0] sel_neg_ch,
  input wire logic [1:0] sel_gain,
  input wire logic [1:0] ref_active,
  input wire logic       int_ref_en
);
  logic busy_r;
  logic busy_nxt;
  // Running conversion, from start pulse to done strobe
  always_comb begin
    busy_nxt = busy_r;
    if (conv_start) busy_nxt = 1'b1;
    else if (conv_done_in) busy_nxt = 1'b0;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) busy_r <= 1'b0;
    else busy_r <= busy_nxt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer not on time");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer not on time");
  sel_hold_a: assert property (busy_r |=>
    $stable({sel_diff, sel_pos_ch, sel_neg_ch, sel_gain, ref_active}))
    else $error("selection moved during conversion");
  start_busy_a: assert property (
    busy_r && !conv_done_in |-> !conv_start)
    else $error("start while busy");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  amp_pair_a: assert property (sel_gain != 2'd0 |-> sel_diff &&
    sel_pos_ch[3:1] == sel_neg_ch[3:1] && !sel_neg_ch[0])
    else $error("amplified pair routing wrong");
  unity_neg_a: assert property (sel_diff && sel_gain == 2'd0 |->
    sel_neg_ch[2:0] inside {3'd1, 3'd2})
    else $error("unity pair negative input wrong");
  ref_int_a: assert property (int_ref_en == ref_active[1])
    else $error("internal reference enable wrong");
endmodule : adcs_top_monitor
bind adcs_top adcs_top_monitor i_mon (.clk_sys, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .conv_start,
  .conv_done_in, .sel_diff, .sel_pos_ch, .sel_neg_ch, .sel_gain,
  .ref_active, .int_ref_en);

// ---- testbench/tb_top.sv ----
// Self-checking bench of the converter select block
`timescale 1ns/1ps
`include "adcs_defs.svh"
module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, trig_in = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, conv_start, sel_diff, int_ref_en, cmp_mux_en, irq;
  logic conv_done_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, sel_gain, sel_special, ref_active;
  logic [3:0] sel_pos_ch, sel_neg_ch;
  logic [31:0] s_axi_rdata;
  logic [10:0] conv_raw, raw_set = 11'h000;
  logic [7:0] lat = 8'h04, rd;
  logic [1:0] rr;
  int fails = 0, samples_checked = 0, starts = 0, cyc = 0, n0 = 0;
  // Rows: code, diff, positive, negative, gain
  logic [16:0] sel_rows [14] = '{
    {6'h00,1'b0,4'h0,4'h0,2'h0}, {6'h07,1'b0,4'h7,4'h0,2'h0},
    {6'h08,1'b1,4'h0,4'h0,2'h1}, {6'h09,1'b1,4'h1,4'h0,2'h1},
    {6'h0A,1'b1,4'h0,4'h0,2'h2}, {6'h0B,1'b1,4'h1,4'h0,2'h2},
    {6'h0C,1'b1,4'h2,4'h2,2'h1}, {6'h0D,1'b1,4'h3,4'h2,2'h1},
    {6'h0E,1'b1,4'h2,4'h2,2'h2}, {6'h0F,1'b1,4'h3,4'h2,2'h2},
    {6'h10,1'b1,4'h0,4'h1,2'h0}, {6'h11,1'b1,4'h1,4'h1,2'h0},
    {6'h12,1'b1,4'h2,4'h1,2'h0}, {6'h20,1'b0,4'h8,4'h0,2'h0}};
  // Rows: left_justify and code, raw input, result_high, result_low
  logic [32:0] cv_rows [8] = '{
    {6'h03,11'h3FF,8'h03,8'hFF}, {6'h03,11'h500,8'h03,8'hFF},
    {6'h03,11'h000,8'h00,8'h00}, {6'h23,11'h3FF,8'hFF,8'hC0},
    {6'h10,11'h400,8'h02,8'h00}, {6'h10,11'h3FF,8'h01,8'hFF},
    {6'h2D,11'h670,8'h9C,8'h00}, {6'h08,11'h002,8'h00,8'h02}};

  adcs_top i_dut (.*);
  adcs_analog_model i_ana (.clk_sys(clk_sys), .nrst(nrst),
    .raw_set(raw_set), .lat(lat), .conv_start(conv_start),
    .conv_done_in(conv_done_in), .conv_raw(conv_raw));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (conv_start === 1'b1) starts++;
  // Hang guard: a run far longer than the planned traffic
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [10:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle
  // Ready is sampled mid-cycle so the release lands just after the take
  task automatic axi_wr(input logic [7:0] a, d);
    logic ta, tw, tv;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tv = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tv);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic ta, tv;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      rd = s_axi_rdata[7:0];
      rr = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tv);
  endtask : axi_rd
  task automatic rdc(input logic [7:0] a, e);
    axi_rd(a);
    chk("rdata", rd, e);
  endtask : rdc
  task automatic conv(input logic [10:0] r, input logic [7:0] l);
    @(posedge clk_sys);
    raw_set <= r;
    lat <= l;
    axi_wr(`ADCS_OFF_CONV, 8'h02);
  endtask : conv
  task automatic wait_done();
    for (int n = 0; n < 200 && conv_done_in !== 1'b1; n++) @(negedge clk_sys);
    idle(3);
  endtask : wait_done
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    idle(3);
    rdc(`ADCS_OFF_INSEL, 8'h00);
    rdc(`ADCS_OFF_CTRLB, 8'h00);
    foreach (sel_rows[i]) begin
      axi_wr(`ADCS_OFF_INSEL, {3'b110, sel_rows[i][15:11]});
      axi_wr(`ADCS_OFF_CTRLB, {4'h0, sel_rows[i][16], 3'h0});
      idle(3);
      chk("sel", {sel_diff, sel_pos_ch, sel_neg_ch, sel_gain},
          sel_rows[i][10:0]);
    end
    for (int r = 0; r < 4; r++) begin
      axi_wr(`ADCS_OFF_INSEL, {r[1:0], 6'h00});
      idle(3);
      chk("ref", {ref_active, int_ref_en}, {r[1:0], r[1]});
    end
    axi_wr(`ADCS_OFF_CTRLB, 8'hFF);
    rdc(`ADCS_OFF_CTRLB, 8'h4F);
    chk("cmp", cmp_mux_en, 1'b1);
    axi_wr(`ADCS_OFF_CTRLB, 8'h00);
    axi_rd(8'h40);
    chk("resp", rr, `ADCS_RESP_SLVERR);
    axi_wr(8'h40, 8'h00);
    chk("bresp", rr, `ADCS_RESP_SLVERR);
    axi_wr(`ADCS_OFF_INSEL, 8'hDF);
    idle(3);
    chk("spc", sel_special, 2'd2);
    axi_wr(`ADCS_OFF_IRQ_MASK, 8'h01);
    // Last row is a same-channel pair for offset measurement
    foreach (cv_rows[i]) begin
      axi_wr(`ADCS_OFF_INSEL, {2'b11, cv_rows[i][32:27]});
      conv(cv_rows[i][26:16], 8'h04);
      wait_done();
      chk("irq", irq, 1'b1);
      rdc(`ADCS_OFF_RES_HIGH, cv_rows[i][15:8]);
      rdc(`ADCS_OFF_RES_LOW, cv_rows[i][7:0]);
      rdc(`ADCS_OFF_IRQ_STAT, 8'h01);
      idle(2);
      chk("irq", irq, 1'b0);
    end
    axi_wr(`ADCS_OFF_IRQ_MASK, 8'h00);
    axi_wr(`ADCS_OFF_INSEL, 8'hC3);
    conv(11'h270, 8'h04);
    wait_done();
    chk("irq", irq, 1'b0);
    rdc(`ADCS_OFF_IRQ_STAT, 8'h01);
    n0 = starts;
    conv(11'h001, 8'd40);
    axi_wr(`ADCS_OFF_INSEL, 8'hE5);
    axi_wr(`ADCS_OFF_CONV, 8'h02);
    idle(1);
    chk("sel", sel_pos_ch, 4'h3);
    rdc(`ADCS_OFF_RES_HIGH, 8'h9C);
    rdc(`ADCS_OFF_RES_LOW, 8'h00);
    wait_done();
    chk("starts", starts - n0, 11'h001);
    chk("sel", sel_pos_ch, 4'h5);
    rdc(`ADCS_OFF_RES_LOW, 8'h40);
    axi_wr(`ADCS_OFF_CONV, 8'h01);
    for (int k = 0; k < 8; k++) begin
      axi_wr(`ADCS_OFF_CTRLB, k[7:0]);
      n0 = starts;
      @(posedge clk_sys) trig_in <= ~(8'h01 << k);
      idle(4);
      @(posedge clk_sys) trig_in <= 8'hFF;
      idle(5);
      chk("starts", starts - n0, 11'h001);
      wait_done();
      @(posedge clk_sys) trig_in <= 8'h00;
    end
    print_verdict();
  end
endmodule : tb_top
